//--- src/intc_defs.svh
`ifndef INTC_DEFS_SVH
`define INTC_DEFS_SVH

// Register byte addresses on the APB port
`define SIS_ADDR 8'h00
`define CTRL_ADDR 8'h04
`define PEND_ADDR 8'h08
`define VEC_ADDR 8'h0C
`define EXTCFG_ADDR 8'h10
`define PERCLR_ADDR 8'h14

// System integrity status field positions
`define SIS_WDG_BIT 4
`define SIS_LOCK_BIT 3
`define SIS_UV_BIT 2
`define SIS_WARN_BIT 1
`define SIS_WARNIE_BIT 0
`define SIS_RESET 8'h00

// Control register: bit 0 is the global mask
`define CTRL_MASK_BIT 0

// Vector addresses
`define VEC_RESET 16'hFFFE
`define VEC_TRAP 16'hFFFC
`define VEC_TOP 16'hFFFA

// Source slots
`define NSRC 14
`define SLOT_AWU 0
`define SLOT_WARN 7
`define SLOT_ATOVF 9
`define SLOT_RTC1 11
`define UNUSED_SLOTS 14'h2040
// Sources that may leave halt (external lines, SPI); the auto-wakeup bit is masked off in halt
`define HALT_WAKE 14'h101F
// Sources that may leave the timed halt mode
`define TIMED_WAKE 14'h0A00

`endif

//--- src/intc_pkg.sv
package intc_pkg;
    typedef enum logic [1:0] {
        SENS_FALL_LOW,
        SENS_RISE,
        SENS_FALL,
        SENS_BOTH
    } sens_t;
    typedef enum logic [1:0] {
        MODE_RUN,
        MODE_WAIT,
        MODE_HALT,
        MODE_TIMED_HALT
    } power_mode_t;
    typedef logic [13:0] src_vec_t;
endpackage

//--- src/intc_if.sv
// Pending set between the core and the priority picker
interface intc_if;
    logic [13:0] pending;
    logic found;
    logic [3:0] slot;
    modport picker(input pending, output found, slot);
    modport owner(output pending, input found, slot);
endinterface

//--- src/ext_edge.sv
// Edge or level detection for one external line
module ext_edge
    import intc_pkg::*;
(
    input wire logic clk,
    input wire logic resetn,
    input wire logic pin,
    input wire intc_pkg::sens_t sens,
    output logic hit
);
    logic last_reg;
    logic rise;
    logic fall;

    // Previous level, reset high so no false rising edge
    always_ff @(posedge clk) begin
        if (!resetn) begin
            last_reg <= 1'b1;
        end else begin
            last_reg <= pin;
        end
    end

    assign rise = pin & ~last_reg;
    assign fall = ~pin & last_reg;
    assign hit = (sens == SENS_FALL_LOW) ? ~pin :
                 (sens == SENS_RISE) ? rise :
                 (sens == SENS_FALL) ? fall : (rise | fall);
endmodule

//--- src/prio_pick.sv
`include "intc_defs.svh"
// Fixed priority: lowest slot number wins
module prio_pick (
    intc_if.picker pi
);
    always_comb begin
        pi.found = 1'b0;
        pi.slot = 4'h0;
        for (int i = `NSRC - 1; i >= 0; i--) begin
            if (pi.pending[i]) begin
                pi.found = 1'b1;
                pi.slot = 4'(i);
            end
        end
    end
endmodule

//--- src/intc_top.sv
// The register offsets and the APB slave port were left to the implementer.
`include "intc_defs.svh"
module intc_top
    import intc_pkg::*;
(
    input wire logic CLK,
    input wire logic RESETN,
    input wire logic PSEL,
    input wire logic PENABLE,
    input wire logic PWRITE,
    input wire logic [7:0] PADDR,
    input wire logic [31:0] PWDATA,
    output logic [31:0] PRDATA,
    output logic PREADY,
    output logic PSLVERR,
    input wire logic WDG_RESET,
    input wire logic UV_RESET,
    input wire logic PLL_LOCK,
    input wire logic SUPPLY_LOW,
    input wire logic [3:0] EXT_PIN,
    input wire logic [3:0] EXT_GROUP_LOW,
    input wire logic [13:0] PERIPH_FLAG,
    input wire logic [13:0] PERIPH_ENABLE,
    input wire logic [13:0] PERIPH_ASSOC_ACCESS,
    input wire logic INSTR_END,
    input wire logic TRAP_EXEC,
    input wire logic RETURN_EXEC,
    input wire intc_pkg::power_mode_t POWER_MODE,
    output logic GLOBAL_MASK,
    output logic TAKE_IRQ,
    output logic [15:0] VECTOR,
    output logic WAKE
);
    import intc_pkg::*;

    logic [7:0] sis_reg;
    logic mask_reg;
    logic [13:0] ext_pend_reg;
    logic warn_pend_reg;
    logic warn_last_reg;
    logic [13:0] per_armed_reg;
    logic [7:0] sens_reg;
    logic [31:0] prdata_reg;
    logic pready_reg;
    logic pslverr_reg;
    logic take_reg;
    logic [15:0] vector_reg;
    logic wake_reg;
    logic [3:0] ext_hit;
    logic [3:0] ext_hit_gated;
    src_vec_t pend_all;
    src_vec_t wake_set;
    logic acc;
    logic wr;
    logic rd;
    logic map_hit;
    logic halted;
    logic warn_rise;
    logic take_now;
    logic trap_now;
    logic [31:0] rdata_next;
    logic [7:0] sis_next;
    intc_if pif();

    function automatic logic [15:0] vec_of(input logic [3:0] slot);
        vec_of = `VEC_TOP - {11'h000, slot, 1'b0};
    endfunction

    // Four external line detectors
    for (genvar g = 0; g < 4; g++) begin : g_ext
        ext_edge u_edge (
            .clk(CLK),
            .resetn(RESETN),
            .pin(EXT_PIN[g]),
            .sens(sens_t'(sens_reg[2*g +: 2])),
            .hit(ext_hit[g])
        );
    end
    prio_pick u_pick (
        .pi(pif.picker)
    );

    // APB decode; slave always answers in the access cycle
    assign acc = PSEL & PENABLE;
    assign wr = acc & PWRITE;
    assign rd = acc & ~PWRITE;
    assign map_hit = (PADDR == `SIS_ADDR) || (PADDR == `CTRL_ADDR) || (PADDR == `PEND_ADDR) ||
                     (PADDR == `VEC_ADDR) || (PADDR == `EXTCFG_ADDR) || (PADDR == `PERCLR_ADDR);
    assign halted = (POWER_MODE == MODE_HALT) || (POWER_MODE == MODE_TIMED_HALT);

    // Combined line masked while any enabled member pin is low
    assign ext_hit_gated = ext_hit & ~EXT_GROUP_LOW;
    assign warn_rise = SUPPLY_LOW & ~warn_last_reg;

    // Pending set: externals, warning, enabled and armed peripherals
    always_comb begin
        pend_all = ext_pend_reg | (PERIPH_FLAG & PERIPH_ENABLE & per_armed_reg);
        pend_all[`SLOT_WARN] = warn_pend_reg;
        pend_all = pend_all & ~`UNUSED_SLOTS;
    end
    assign pif.pending = pend_all;

    // Serviced only at a boundary with mask clear; trap ignores mask
    assign take_now = INSTR_END & ~mask_reg & pif.found;
    assign trap_now = TRAP_EXEC & INSTR_END;

    // Wake sources per power mode
    always_comb begin
        wake_set = pend_all;
        if (POWER_MODE == MODE_HALT) begin
            wake_set = pend_all & `HALT_WAKE & ~(14'h0001 << `SLOT_AWU);
        end else if (POWER_MODE == MODE_TIMED_HALT) begin
            wake_set = pend_all & (`TIMED_WAKE | (14'h0001 << `SLOT_AWU));
        end
    end

    // Status register next value; frozen during halt
    always_comb begin
        sis_next = sis_reg;
        if (!halted) begin
            sis_next[`SIS_LOCK_BIT] = PLL_LOCK;
            sis_next[`SIS_WARN_BIT] = SUPPLY_LOW;
            if (rd && PADDR == `SIS_ADDR) begin
                sis_next[`SIS_UV_BIT] = 1'b0;
            end
            if (wr && PADDR == `SIS_ADDR) begin
                sis_next[`SIS_WARNIE_BIT] = PWDATA[`SIS_WARNIE_BIT];
                if (!PWDATA[`SIS_WDG_BIT]) begin
                    sis_next[`SIS_WDG_BIT] = 1'b0;
                end
            end
        end
        sis_next[7:5] = 3'h0;
    end

    // Read mux
    always_comb begin
        rdata_next = 32'h0000_0000;
        case (PADDR)
            `SIS_ADDR: rdata_next = {24'h000000, sis_reg};
            `CTRL_ADDR: rdata_next = {31'h0000_0000, mask_reg};
            `PEND_ADDR: rdata_next = {18'h00000, pend_all};
            `VEC_ADDR: rdata_next = {16'h0000, vector_reg};
            `EXTCFG_ADDR: rdata_next = {24'h000000, sens_reg};
            default: rdata_next = 32'h0000_0000;
        endcase
    end

    // APB answer registers
    always_ff @(posedge CLK) begin
        if (!RESETN) begin
            prdata_reg <= 32'h0000_0000;
            pready_reg <= 1'b0;
            pslverr_reg <= 1'b0;
        end else begin
            pready_reg <= PSEL & ~PENABLE;
            pslverr_reg <= PSEL & ~PENABLE & ~map_hit;
            prdata_reg <= rdata_next;
        end
    end

    // Reset flags: an undervoltage reset outranks the watchdog one
    always_ff @(posedge CLK) begin
        if (UV_RESET) begin
            sis_reg <= `SIS_RESET | (8'h01 << `SIS_UV_BIT);
        end else if (WDG_RESET) begin
            sis_reg <= {sis_reg[7:3], sis_reg[`SIS_UV_BIT], 2'b00} | (8'h01 << `SIS_WDG_BIT);
        end else if (!RESETN) begin
            sis_reg <= {3'h0, 1'b0, 1'b0, sis_reg[`SIS_UV_BIT], 2'b00};
        end else begin
            sis_reg <= sis_next;
        end
    end

    // Global mask: set at reset and on entry, cleared on return
    always_ff @(posedge CLK) begin
        if (!RESETN) begin
            mask_reg <= 1'b1;
        end else if (take_now || trap_now) begin
            mask_reg <= 1'b1;
        end else if (RETURN_EXEC) begin
            mask_reg <= 1'b0;
        end else if (wr && PADDR == `CTRL_ADDR) begin
            mask_reg <= PWDATA[`CTRL_MASK_BIT];
        end
    end

    // Sensitivity codes: writable only while masked, change drops pending
    always_ff @(posedge CLK) begin
        if (!RESETN) begin
            sens_reg <= 8'h00;
        end else if (wr && PADDR == `EXTCFG_ADDR && mask_reg) begin
            sens_reg <= PWDATA[7:0];
        end
    end

    // External latches; a new edge wins over entry clear
    always_ff @(posedge CLK) begin
        if (!RESETN) begin
            ext_pend_reg <= 14'h0000;
        end else begin
            for (int i = 0; i < 4; i++) begin
                if (ext_hit_gated[i]) begin
                    ext_pend_reg[i+1] <= 1'b1;
                end else if ((take_now && pif.slot == 4'(i + 1)) ||
                             (wr && PADDR == `EXTCFG_ADDR && mask_reg &&
                              PWDATA[2*i +: 2] != sens_reg[2*i +: 2])) begin
                    ext_pend_reg[i+1] <= 1'b0;
                end
            end
        end
    end

    // Warning request: latched on rise when enabled, cleared on entry
    always_ff @(posedge CLK) begin
        if (!RESETN) begin
            warn_pend_reg <= 1'b0;
            warn_last_reg <= 1'b0;
        end else begin
            warn_last_reg <= SUPPLY_LOW;
            if (warn_rise && sis_reg[`SIS_WARNIE_BIT]) begin
                warn_pend_reg <= 1'b1;
            end else if (take_now && pif.slot == 4'(`SLOT_WARN)) begin
                warn_pend_reg <= 1'b0;
            end
        end
    end

    // Peripheral latch: clear write or status-then-associated access disarms
    always_ff @(posedge CLK) begin
        if (!RESETN) begin
            per_armed_reg <= 14'h3FFF;
        end else begin
            for (int i = 0; i < `NSRC; i++) begin
                if (!PERIPH_FLAG[i]) begin
                    per_armed_reg[i] <= 1'b1;
                end else if ((wr && PADDR == `PERCLR_ADDR && PWDATA[i]) || PERIPH_ASSOC_ACCESS[i]) begin
                    per_armed_reg[i] <= 1'b0;
                end
            end
        end
    end

    // Entry pulse, vector and wake outputs
    always_ff @(posedge CLK) begin
        if (!RESETN) begin
            take_reg <= 1'b0;
            vector_reg <= `VEC_RESET;
            wake_reg <= 1'b0;
        end else begin
            take_reg <= take_now | trap_now;
            wake_reg <= (POWER_MODE != MODE_RUN) && (wake_set != 14'h0000);
            if (trap_now) begin
                vector_reg <= `VEC_TRAP;
            end else if (take_now) begin
                vector_reg <= vec_of(pif.slot);
            end
        end
    end

    assign PRDATA = prdata_reg;
    assign PREADY = pready_reg;
    assign PSLVERR = pslverr_reg;
    assign GLOBAL_MASK = mask_reg;
    assign TAKE_IRQ = take_reg;
    assign VECTOR = vector_reg;
    assign WAKE = wake_reg;

    mask_after_reset_a: assert property (@(posedge CLK) !RESETN |=> GLOBAL_MASK)
        else $error("mask not set after reset");
    entry_sets_mask_a: assert property (@(posedge CLK) disable iff (!RESETN) take_now |=> GLOBAL_MASK && TAKE_IRQ)
        else $error("entry did not set mask");
    trap_vector_a: assert property (@(posedge CLK) disable iff (!RESETN) trap_now |=> VECTOR == `VEC_TRAP)
        else $error("trap vector wrong");
    masked_no_take_a: assert property (@(posedge CLK) disable iff (!RESETN) mask_reg && !trap_now |=> !TAKE_IRQ)
        else $error("taken while masked");
    lock_follows_a: assert property (@(posedge CLK) disable iff (!RESETN || halted || UV_RESET || WDG_RESET)
        1'b1 |=> sis_reg[`SIS_LOCK_BIT] == $past(PLL_LOCK))
        else $error("lock flag stale");
    uv_read_clear_a: assert property (@(posedge CLK) disable iff (!RESETN || halted || UV_RESET || WDG_RESET)
        rd && PADDR == `SIS_ADDR |=> !sis_reg[`SIS_UV_BIT])
        else $error("undervoltage flag not cleared");
    wdg_sets_flag_a: assert property (@(posedge CLK) WDG_RESET && !UV_RESET |=> sis_reg[`SIS_WDG_BIT])
        else $error("watchdog flag not set");
    return_clears_a: assert property (@(posedge CLK) disable iff (!RESETN)
        RETURN_EXEC && !take_now && !trap_now |=> !GLOBAL_MASK)
        else $error("return left mask set");
    reserved_zero_a: assert property (@(posedge CLK) disable iff (!RESETN) sis_reg[7:5] == 3'h0)
        else $error("reserved bits nonzero");
endmodule

//--- test/core_model.sv
// Core stand-in: instruction boundaries, trap and return pulses
module core_model (
    input wire logic clk,
    input wire logic resetn,
    input wire logic trap_req,
    input wire logic ret_req,
    output logic instr_end,
    output logic trap_exec,
    output logic return_exec
);
    timeunit 1ns;
    timeprecision 1ps;
    logic [1:0] cnt_reg;
    // Every fourth cycle ends an instruction; trap rides on that boundary only
    always_ff @(posedge clk) begin
        if (!resetn) begin
            cnt_reg <= 2'h0;
            instr_end <= 1'b0;
            trap_exec <= 1'b0;
            return_exec <= 1'b0;
        end else begin
            cnt_reg <= cnt_reg + 2'h1;
            instr_end <= (cnt_reg == 2'h3);
            trap_exec <= trap_req && (cnt_reg == 2'h3);
            return_exec <= ret_req;
        end
    end
endmodule

//--- test/interrupt_and_reset_flags_tb.sv
`include "intc_defs.svh"
module interrupt_and_reset_flags_tb;
    timeunit 1ns;
    timeprecision 1ps;
    import intc_pkg::*;
    logic clk = 1'b0, resetn = 1'b0, psel = 1'b0, penable = 1'b0, pwrite = 1'b0;
    logic [7:0] paddr = 8'h00;
    logic [31:0] pwdata = 32'h0, prdata, rdat;
    logic pready, pslverr, err, wdg = 1'b0, uv = 1'b0, pll = 1'b1, low = 1'b0;
    logic [3:0] ext_pin = 4'hF;
    logic [13:0] pflag = 14'h0, pen = 14'h0;
    logic [3:0] grp_low = 4'h0;
    logic [13:0] assoc = 14'h0;
    logic instr_end, trap_exec, return_exec, trap_req = 1'b0, ret_req = 1'b0;
    power_mode_t pmode = MODE_RUN;
    logic global_mask, take_irq, wake;
    logic [15:0] vector;
    int miscompares = 0, cmp_count = 0;

    // Half-period toggle gives 200 MHz
    always #2.5 clk = ~clk;

    intc_top DUT (.CLK(clk), .RESETN(resetn), .PSEL(psel), .PENABLE(penable),
        .PWRITE(pwrite), .PADDR(paddr), .PWDATA(pwdata), .PRDATA(prdata),
        .PREADY(pready), .PSLVERR(pslverr), .WDG_RESET(wdg), .UV_RESET(uv),
        .PLL_LOCK(pll), .SUPPLY_LOW(low), .EXT_PIN(ext_pin), .EXT_GROUP_LOW(grp_low),
        .PERIPH_FLAG(pflag), .PERIPH_ENABLE(pen), .PERIPH_ASSOC_ACCESS(assoc),
        .INSTR_END(instr_end), .TRAP_EXEC(trap_exec), .RETURN_EXEC(return_exec),
        .POWER_MODE(pmode), .GLOBAL_MASK(global_mask), .TAKE_IRQ(take_irq),
        .VECTOR(vector), .WAKE(wake));

    core_model core (.clk(clk), .resetn(resetn), .trap_req(trap_req),
        .ret_req(ret_req), .instr_end(instr_end), .trap_exec(trap_exec),
        .return_exec(return_exec));

    task conclude;
        if (miscompares == 0 && cmp_count > 0) begin
            $display("All checks passed");
        end else begin
            $display("Checks failed");
        end
        $finish;
    endtask

    task chk(input logic [31:0] got, input logic [31:0] exp);
        cmp_count++;
        if (got !== exp) begin
            miscompares++;
            $display("unexpected at %0t: got %h expected %h", $time, got, exp);
        end
    endtask

    // One APB transfer; an idle cycle follows so calls never collide
    task apb(input logic w, input logic [7:0] a, input logic [31:0] d);
        int n;
        psel <= 1'b1;
        pwrite <= w;
        paddr <= a;
        pwdata <= d;
        @(posedge clk);
        penable <= 1'b1;
        n = 0;
        do begin
            @(posedge clk);
            n++;
        end while (pready !== 1'b1 && n < 20);
        // A slave that never answers counts against the run
        if (pready !== 1'b1) begin
            miscompares++;
            $display("unexpected at %0t: got %h expected %h", $time, pready, 1'b1);
        end
        rdat = prdata;
        err = pslverr;
        psel <= 1'b0;
        penable <= 1'b0;
        @(posedge clk);
    endtask

    task rd(input logic [7:0] a, input logic [31:0] e);
        apb(1'b0, a, 32'h0);
        chk(rdat, e);
    endtask

    // Reset with optional watchdog or undervoltage cause held alongside
    task rst(input logic w, input logic u);
        resetn <= 1'b0;
        wdg <= w;
        uv <= u;
        repeat (5) @(posedge clk);
        resetn <= 1'b1;
        wdg <= 1'b0;
        uv <= 1'b0;
        @(posedge clk);
    endtask

    // Bounded wait for entry, then vector and mask
    task irq(input logic [15:0] v);
        int n;
        n = 0;
        while (take_irq !== 1'b1 && n < 40) begin
            @(posedge clk);
            n++;
        end
        // No entry within the limit is a mismatch, not a silent pass
        if (take_irq !== 1'b1) begin
            miscompares++;
            $display("unexpected at %0t: got %h expected %h", $time, take_irq, 1'b1);
        end
        chk({16'h0, vector}, {16'h0, v});
        chk({31'h0, global_mask}, 32'h1);
    endtask

    task ret;
        ret_req <= 1'b1;
        @(posedge clk);
        ret_req <= 1'b0;
        repeat (3) @(posedge clk);
    endtask

    initial begin
        repeat (20000) @(posedge clk);
        miscompares++;
        conclude;
    end

    initial begin
        rst(1'b0, 1'b1);
        rd(`SIS_ADDR, 32'h0C);
        rd(`SIS_ADDR, 32'h08);
        rd(`CTRL_ADDR, 32'h01);
        rst(1'b0, 1'b1);
        rst(1'b1, 1'b0);
        rd(`SIS_ADDR, 32'h1C);
        apb(1'b1, `SIS_ADDR, 32'h0);
        rd(`SIS_ADDR, 32'h08);
        rst(1'b1, 1'b0);
        rst(1'b0, 1'b1);
        rst(1'b0, 1'b0);
        rd(`SIS_ADDR, 32'h0C);
        rst(1'b1, 1'b0);
        rd(`SIS_ADDR, 32'h18);
        pll <= 1'b0;
        repeat (2) @(posedge clk);
        rd(`SIS_ADDR, 32'h10);
        pll <= 1'b1;
        apb(1'b1, `SIS_ADDR, 32'h01);
        low <= 1'b1;
        repeat (3) @(posedge clk);
        rd(`SIS_ADDR, 32'h0B);
        rd(`PEND_ADDR, 32'h80);
        apb(1'b1, `CTRL_ADDR, 32'h0);
        irq(16'hFFEC);
        rd(`PEND_ADDR, 32'h0);
        ret;
        chk({31'h0, global_mask}, 32'h0);
        low <= 1'b0;
        apb(1'b1, `CTRL_ADDR, 32'h1);
        // Each sensitivity code on line zero: fall, then rise, then enter
        for (int c = 0; c < 4; c++) begin
            apb(1'b1, `EXTCFG_ADDR, 32'(c));
            ext_pin[0] <= 1'b0;
            repeat (4) @(posedge clk);
            rd(`PEND_ADDR, (c == 1) ? 32'h0 : 32'h2);
            ext_pin[0] <= 1'b1;
            repeat (4) @(posedge clk);
            apb(1'b1, `CTRL_ADDR, 32'h0);
            irq(16'hFFF8);
            rd(`PEND_ADDR, 32'h0);
        end
        // Combined line held low by a member pin: no request on either edge
        grp_low <= 4'h1;
        ext_pin[0] <= 1'b0;
        repeat (4) @(posedge clk);
        rd(`PEND_ADDR, 32'h0);
        ext_pin[0] <= 1'b1;
        repeat (4) @(posedge clk);
        rd(`PEND_ADDR, 32'h0);
        grp_low <= 4'h0;
        pen <= 14'h1020;
        pflag <= 14'h1020;
        ext_pin[1] <= 1'b0;
        repeat (4) @(posedge clk);
        ext_pin[1] <= 1'b1;
        rd(`PEND_ADDR, 32'h1024);
        apb(1'b1, `CTRL_ADDR, 32'h0);
        irq(16'hFFF6);
        ret;
        irq(16'hFFF0);
        apb(1'b1, `PERCLR_ADDR, 32'h20);
        ret;
        irq(16'hFFE2);
        pflag <= 14'h0;
        pen <= 14'h0400;
        repeat (2) @(posedge clk);
        pflag <= 14'h0400;
        repeat (3) @(posedge clk);
        rd(`PEND_ADDR, 32'h400);
        apb(1'b1, `PERCLR_ADDR, 32'h400);
        rd(`PEND_ADDR, 32'h0);
        // Re-arm, then clear by the associated-register access
        pflag <= 14'h0;
        @(posedge clk);
        pflag <= 14'h0400;
        repeat (2) @(posedge clk);
        rd(`PEND_ADDR, 32'h400);
        assoc <= 14'h0400;
        @(posedge clk);
        assoc <= 14'h0;
        rd(`PEND_ADDR, 32'h0);
        pen <= 14'h0020;
        pflag <= 14'h0020;
        pmode <= MODE_HALT;
        repeat (4) @(posedge clk);
        chk({31'h0, wake}, 32'h0);
        pmode <= MODE_WAIT;
        repeat (4) @(posedge clk);
        chk({31'h0, wake}, 32'h1);
        pmode <= MODE_TIMED_HALT;
        repeat (4) @(posedge clk);
        chk({31'h0, wake}, 32'h0);
        pen <= 14'h0220;
        pflag <= 14'h0220;
        repeat (4) @(posedge clk);
        chk({31'h0, wake}, 32'h1);
        pmode <= MODE_RUN;
        apb(1'b1, `PERCLR_ADDR, 32'h220);
        trap_req <= 1'b1;
        irq(16'hFFFC);
        trap_req <= 1'b0;
        apb(1'b0, 8'h3C, 32'h0);
        chk({31'h0, err}, 32'h1);
        chk(rdat, 32'h0);
        conclude;
    end
endmodule
